// ---- verilog/acq_wfm_pkg.sv ----
/*
 * Shared constants of the acquisition and waveform control block.
 * Assumes a 40 MHz system clock and a 32-bit APB register bus.
 */
package acq_wfm_pkg;
  // geometry
  localparam int N_AI = 4;
  localparam int N_AO = 2;
  localparam int CH_W = 2;
  localparam int ADC_W = 16;
  localparam int DAC_W = 18;
  localparam int WORD_W = 32;
  localparam int PTR_W = 16;
  localparam int ADDR_W = 8;
  localparam int SYNC_LINES = 7;
  localparam int SYNC_SEL_W = 3;
  localparam int DIV_W = 3;
  localparam int DCNT_W = 10;
  localparam int ACC_W = 38;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CHAN_EN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GAIN = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ATTEN = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_BUF_LEN = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_POST_CNT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ATRIG = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_TUNE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_DIV = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h2C;
  // control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_START_LSB = 2;
  localparam int CTRL_STOP_LSB = 4;
  localparam int CTRL_WFM_SRC_BIT = 6;
  localparam int CTRL_WFM_TRIG_BIT = 7;
  localparam int CTRL_SYNC_LSB = 8;
  // command bits (write pulses)
  localparam int CMD_ARM = 0;
  localparam int CMD_SW_START = 1;
  localparam int CMD_SW_STOP = 2;
  localparam int CMD_ABORT = 3;
  localparam int CMD_WFM_RUN = 4;
  localparam int CMD_WFM_HALT = 5;
  // gain field: code, then coupling
  localparam int GAIN_FLD_W = 5;
  localparam int GAIN_CODE_W = 4;
  localparam logic [GAIN_CODE_W-1:0] GAIN_CODE_MAX = 4'h8;
  localparam logic [GAIN_CODE_W-1:0] GAIN_CODE_0DB = 4'h2;
  localparam int ATTEN_W = 2;
  localparam logic [ATTEN_W-1:0] ATTEN_CODE_MAX = 2'h2;
  // analog trigger fields
  localparam int ATRIG_CH_LSB = 16;
  localparam int ATRIG_SLOPE_BIT = 18;
  // divider fields
  localparam int DIV_AI_LSB = 0;
  localparam int DIV_AO_LSB = 4;
  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_STOP_SEEN = 1;
  localparam int ST_DIG_LAT = 2;
  localparam int ST_WFM_RUN = 3;
  localparam int ST_WFM_LIVE = 4;
  localparam int ST_HALF0 = 5;
  localparam int ST_HALF1 = 6;
  localparam int ST_OVERRUN = 7;
  localparam int ST_UNDERRUN = 8;
  localparam int ST_WFM_ARMED = 9;
  localparam int ST_PTR_LSB = 16;
  // reset values
  localparam logic [PTR_W-1:0] BUF_LEN_RST = 16'h0400;
  localparam logic [WORD_W-1:0] POST_CNT_RST = 32'h0000_0100;
  localparam logic [N_AI-1:0] CHAN_EN_RST = 4'hF;
  // timing
  localparam longint CLK_HZ = 40_000_000;
  localparam longint AI_RATE_MAX_HZ = 204_800;
  localparam int WFM_PRESCALE_LOG2 = 2;
  localparam logic [WORD_W-1:0] TUNE_MAX = WORD_W'((AI_RATE_MAX_HZ * (64'd1 << ACC_W)) / CLK_HZ);
  localparam logic [7:0] DIG_LAT_SCANS = 8'd42;
  localparam logic [7:0] WFM_LAT_MIN = 8'd30;
  localparam logic [7:0] WFM_LAT_MAX = 8'd40;
  // enumerations
  typedef enum logic [1:0] {MODE_POST = 2'b00, MODE_PRE = 2'b01, MODE_DBL = 2'b10} acq_mode_e;
  typedef enum logic [1:0] {SRC_SW = 2'b00, SRC_PIN = 2'b01, SRC_SYNC = 2'b10,
                            SRC_ANALOG = 2'b11} trig_src_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ARMED = 2'b01, ST_RUN = 2'b11,
                            ST_STOPPING = 2'b10} acq_state_e;
endpackage : acq_wfm_pkg

// ---- verilog/acq_wfm_ctrl.sv ----
/*
 * Control for simultaneous inputs and outputs: scan, formatting, triggers, clocks.
 * Assumes stable converter data around valid, a same-clock host stream and APB.
 */
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - ascending scan, per-channel enable
// - 16-bit result left-justified in 32
// - gain -20..60 dB steps, AC/DC coupling
// - posttrigger: count samples, stop when full
// - pretrigger: ring buffer until stop trigger
// - after stop trigger, programmed count, halt
// - double buffer: host drains other half
// - fine synthesized rate, filter tracks rate
// - internal sample clock only, shared out
// - start trigger: pin, sync bus, software
// - stop trigger: pin, sync bus, software
// - analog trigger any channel, level, slope
// - digital trigger: connector or sync bus
// - digital trigger latency of 42 scans
// - outputs updated together, 18-bit samples
// - output sample is left-justified 32-bit word
// - output attenuation 0, 20, 40 dB
// - outputs update continuously while clock runs
// - one clock, fixed /4, power-of-two dividers
// - output rate bound to running acquisition
// - waveform digital start, 30-40 update latency
module acq_wfm_ctrl (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [acq_wfm_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [acq_wfm_pkg::WORD_W-1:0] I_PWDATA,
  output logic [acq_wfm_pkg::WORD_W-1:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // trigger pins
  input wire logic I_TRIG_PIN,
  input wire logic [acq_wfm_pkg::SYNC_LINES-1:0] I_SYNC_TRIG,
  // input converters
  output logic O_ADC_CONV,
  input wire logic I_ADC_VALID,
  input wire logic [acq_wfm_pkg::N_AI*acq_wfm_pkg::ADC_W-1:0] I_ADC_DATA,
  output logic [acq_wfm_pkg::DIV_W-1:0] O_AAF_RATE,
  output logic [acq_wfm_pkg::N_AI*acq_wfm_pkg::GAIN_CODE_W-1:0] O_GAIN_CODE,
  output logic [acq_wfm_pkg::N_AI-1:0] O_AC_COUPLE,
  // sample stream to host buffer
  output logic O_SMP_VALID,
  output logic [acq_wfm_pkg::WORD_W-1:0] O_SMP_DATA,
  output logic [acq_wfm_pkg::PTR_W-1:0] O_SMP_ADDR,
  input wire logic I_SMP_READY,
  // waveform stream from host
  input wire logic I_WFM_VALID,
  input wire logic [acq_wfm_pkg::N_AO*acq_wfm_pkg::WORD_W-1:0] I_WFM_DATA,
  output logic O_WFM_READY,
  // output converters
  output logic O_DAC_LOAD,
  output logic [acq_wfm_pkg::N_AO*acq_wfm_pkg::DAC_W-1:0] O_DAC_DATA,
  output logic [acq_wfm_pkg::DIV_W-1:0] O_AIF_RATE,
  output logic [acq_wfm_pkg::N_AO*acq_wfm_pkg::ATTEN_W-1:0] O_ATTEN,
  // sync bus clock share
  output logic O_SYNC_CLK
);
  import acq_wfm_pkg::*;

  // lowest set bit of a channel mask
  function automatic logic [CH_W-1:0] first_chan(input logic [N_AI-1:0] m);
    first_chan = '0;
    for (int k = N_AI - 1; k >= 0; k--) begin
      if (m[k]) first_chan = CH_W'(k);
    end
  endfunction : first_chan

  // divider mask for a power-of-two ratio
  function automatic logic [DCNT_W-1:0] div_mask(input logic [DIV_W:0] d);
    div_mask = DCNT_W'((DCNT_W'(1) << d) - DCNT_W'(1));
  endfunction : div_mask

  // register file
  logic [WORD_W-1:0] ctrl_reg;
  logic [N_AI-1:0] chan_en_reg;
  logic [N_AI*GAIN_FLD_W-1:0] gain_reg;
  logic [N_AO*ATTEN_W-1:0] atten_reg;
  logic [PTR_W-1:0] buf_len_reg;
  logic [WORD_W-1:0] post_cnt_reg;
  logic [WORD_W-1:0] atrig_reg;
  logic [WORD_W-1:0] tune_reg;
  logic [DIV_W-1:0] ai_div_reg;
  logic [DIV_W-1:0] ao_div_reg;
  logic [WORD_W-1:0] prdata_reg;
  // acquisition state
  acq_state_e state_reg, state_next;
  logic [PTR_W-1:0] ptr_reg;
  logic [WORD_W-1:0] cnt_reg;
  logic [N_AI-1:0] pend_reg;
  logic [N_AI*ADC_W-1:0] scan_reg;
  logic smp_valid_reg;
  logic [WORD_W-1:0] smp_data_reg;
  logic [PTR_W-1:0] smp_addr_reg;
  logic stop_seen_reg, half0_reg, half1_reg, overrun_reg, underrun_reg;
  logic [7:0] dlat_reg;
  logic dlat_on_reg;
  logic above_reg;
  // waveform state
  logic wfm_armed_reg, wfm_run_reg;
  logic [7:0] wlat_reg;
  logic dac_load_reg;
  logic [N_AO*DAC_W-1:0] dac_data_reg;
  // clock generation
  logic [ACC_W-1:0] acc_reg;
  logic dds_tick_reg, ai_tick_reg;
  logic [DCNT_W-1:0] dcnt_reg;
  // synchronisers: stage 1 feeds stage 2 only
  logic pin_s1, pin_s2, pin_s3;
  logic [SYNC_LINES-1:0] sync_s1, sync_s2, sync_s3;
  logic vld_s1, vld_s2, vld_s3;
  logic [N_AI*ADC_W-1:0] adc_s1, adc_s2;

  // bus decode
  wire acc_ph = I_PSEL && I_PENABLE;
  wire wr = acc_ph && I_PWRITE;
  wire hit_ctrl = (I_PADDR == OFS_CTRL);
  wire hit_cmd = (I_PADDR == OFS_CMD);
  wire hit_en = (I_PADDR == OFS_CHAN_EN);
  wire hit_gain = (I_PADDR == OFS_GAIN);
  wire hit_att = (I_PADDR == OFS_ATTEN);
  wire hit_len = (I_PADDR == OFS_BUF_LEN);
  wire hit_post = (I_PADDR == OFS_POST_CNT);
  wire hit_atr = (I_PADDR == OFS_ATRIG);
  wire hit_tune = (I_PADDR == OFS_TUNE);
  wire hit_div = (I_PADDR == OFS_DIV);
  wire hit_st = (I_PADDR == OFS_STATUS);
  wire hit_cnt = (I_PADDR == OFS_COUNT);
  wire mapped = hit_ctrl | hit_cmd | hit_en | hit_gain | hit_att | hit_len | hit_post |
                hit_atr | hit_tune | hit_div | hit_st | hit_cnt;
  wire [WORD_W-1:0] cmd = (wr && hit_cmd) ? I_PWDATA : '0;
  wire [WORD_W-1:0] w1c = (wr && hit_st) ? I_PWDATA : '0;

  // control fields
  wire [1:0] mode = ctrl_reg[CTRL_MODE_LSB +: 2];
  wire [1:0] start_src = ctrl_reg[CTRL_START_LSB +: 2];
  wire [1:0] stop_src = ctrl_reg[CTRL_STOP_LSB +: 2];
  wire [SYNC_SEL_W-1:0] sync_sel = ctrl_reg[CTRL_SYNC_LSB +: SYNC_SEL_W];
  wire busy = (state_reg != ST_IDLE);
  wire running = (state_reg == ST_RUN) || (state_reg == ST_STOPPING);

  // trigger edges after two-stage sync
  wire pin_edge = pin_s2 && !pin_s3;
  wire sync_edge = sync_s2[sync_sel] && !sync_s3[sync_sel];
  wire scan_edge = vld_s2 && !vld_s3;

  // analog trigger watches any channel, scanned or not
  wire [CH_W-1:0] atr_ch = atrig_reg[ATRIG_CH_LSB +: CH_W];
  wire signed [ADC_W-1:0] atr_smp = adc_s2[atr_ch*ADC_W +: ADC_W];
  wire signed [ADC_W-1:0] atr_lvl = atrig_reg[ADC_W-1:0];
  wire above = (atr_smp >= atr_lvl);
  wire slope_fall = atrig_reg[ATRIG_SLOPE_BIT];
  wire atr_hit = scan_edge && (slope_fall ? (above_reg && !above) : (!above_reg && above));

  // start and stop selection
  wire dig_start = (start_src == SRC_PIN && pin_edge) || (start_src == SRC_SYNC && sync_edge);
  wire start_hit = (state_reg == ST_ARMED) &&
                   ((start_src == SRC_SW && cmd[CMD_SW_START]) || dig_start ||
                    (start_src == SRC_ANALOG && atr_hit));
  wire stop_hit = (state_reg == ST_RUN) && (mode == MODE_PRE) &&
                  ((stop_src == SRC_SW && cmd[CMD_SW_STOP]) ||
                   (stop_src == SRC_PIN && pin_edge) ||
                   (stop_src == SRC_SYNC && sync_edge));

  // sample pointer arithmetic
  wire fire = smp_valid_reg && I_SMP_READY;
  wire can_load = !smp_valid_reg || I_SMP_READY;
  wire [PTR_W-1:0] ptr_inc = PTR_W'(ptr_reg + PTR_W'(1));
  wire [WORD_W-1:0] cnt_inc = WORD_W'(cnt_reg + WORD_W'(1));
  wire wrap = (ptr_inc == buf_len_reg);
  wire mid = (ptr_inc == (buf_len_reg >> 1));
  wire half0_set = fire && (mode == MODE_DBL) && mid;
  wire half1_set = fire && (mode == MODE_DBL) && wrap;
  // host still owns the next half
  wire db_clash = (half0_set && half1_reg) || (half1_set && half0_reg);
  wire post_done = fire && (state_reg == ST_RUN) && (mode == MODE_POST) &&
                   (wrap || cnt_inc == post_cnt_reg);
  wire tail_done = fire && (state_reg == ST_STOPPING) && (cnt_inc == post_cnt_reg);
  wire scan_overrun = scan_edge && running && (pend_reg != '0);
  wire [CH_W-1:0] next_ch = first_chan(pend_reg);

  // state transitions
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      // waiting for software to arm
      ST_IDLE: begin
        if (cmd[CMD_ARM]) state_next = ST_ARMED;
      end
      // waiting for start trigger
      ST_ARMED: begin
        if (cmd[CMD_ABORT]) state_next = ST_IDLE;
        else if (start_hit) state_next = ST_RUN;
      end
      // acquiring
      ST_RUN: begin
        if (cmd[CMD_ABORT] || post_done || db_clash) state_next = ST_IDLE;
        else if (stop_hit) state_next = ST_STOPPING;
      end
      // tail after stop trigger
      ST_STOPPING: begin
        if (cmd[CMD_ABORT] || tail_done) state_next = ST_IDLE;
      end
    endcase
  end

  // effective waveform divider: never faster than a running scan
  wire [DIV_W:0] ai_tot = {1'b0, ai_div_reg};
  wire [DIV_W:0] ao_req = (DIV_W+1)'(ao_div_reg + WFM_PRESCALE_LOG2);
  wire [DIV_W:0] ao_tot = (busy && ao_req < ai_tot) ? ai_tot : ao_req;
  wire [ACC_W:0] acc_sum = {1'b0, acc_reg} + {{(ACC_W+1-WORD_W){1'b0}}, tune_reg};
  wire [DCNT_W-1:0] ai_m = div_mask(ai_tot);
  wire [DCNT_W-1:0] ao_m = div_mask(ao_tot);
  wire ai_tick = dds_tick_reg && ((dcnt_reg & ai_m) == ai_m);
  wire ao_tick = dds_tick_reg && ((dcnt_reg & ao_m) == ao_m);
  wire upd = wfm_run_reg && ao_tick;
  wire wfm_dig = ctrl_reg[CTRL_WFM_SRC_BIT] ? sync_edge : pin_edge;

  // input synchronisers
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      {pin_s1, pin_s2, pin_s3} <= '0;
      {sync_s1, sync_s2, sync_s3} <= '0;
      {vld_s1, vld_s2, vld_s3} <= '0;
      {adc_s1, adc_s2} <= '0;
    end else begin
      {pin_s1, pin_s2, pin_s3} <= {I_TRIG_PIN, pin_s1, pin_s2};
      {sync_s1, sync_s2, sync_s3} <= {I_SYNC_TRIG, sync_s1, sync_s2};
      {vld_s1, vld_s2, vld_s3} <= {I_ADC_VALID, vld_s1, vld_s2};
      {adc_s1, adc_s2} <= {I_ADC_DATA, adc_s1};
    end
  end

  // register writes; tuning locked while acquiring
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      ctrl_reg <= '0;
      chan_en_reg <= CHAN_EN_RST;
      atten_reg <= '0;
      buf_len_reg <= BUF_LEN_RST;
      post_cnt_reg <= POST_CNT_RST;
      atrig_reg <= '0;
      tune_reg <= TUNE_MAX;
      ai_div_reg <= '0;
      ao_div_reg <= '0;
    end else if (wr) begin
      if (hit_ctrl) ctrl_reg <= I_PWDATA;
      if (hit_en) chan_en_reg <= I_PWDATA[N_AI-1:0];
      if (hit_len) buf_len_reg <= I_PWDATA[PTR_W-1:0];
      if (hit_post) post_cnt_reg <= I_PWDATA;
      if (hit_atr) atrig_reg <= I_PWDATA;
      // clamp to top scan rate
      if (hit_tune && !busy) tune_reg <= (I_PWDATA > TUNE_MAX) ? TUNE_MAX : I_PWDATA;
      if (hit_div) begin
        ai_div_reg <= I_PWDATA[DIV_AI_LSB +: DIV_W];
        ao_div_reg <= I_PWDATA[DIV_AO_LSB +: DIV_W];
      end
      // undefined attenuation code ignored
      for (int a = 0; a < N_AO; a++) begin
        if (hit_att && I_PWDATA[a*ATTEN_W +: ATTEN_W] <= ATTEN_CODE_MAX)
          atten_reg[a*ATTEN_W +: ATTEN_W] <= I_PWDATA[a*ATTEN_W +: ATTEN_W];
      end
    end
  end

  // per-channel gain, bad codes ignored
  generate
    for (genvar g = 0; g < N_AI; g++) begin : g_gain
      wire [GAIN_FLD_W-1:0] fld = I_PWDATA[g*GAIN_FLD_W +: GAIN_FLD_W];
      always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) gain_reg[g*GAIN_FLD_W +: GAIN_FLD_W] <= {1'b0, GAIN_CODE_0DB};
        else if (wr && hit_gain && fld[GAIN_CODE_W-1:0] <= GAIN_CODE_MAX)
          gain_reg[g*GAIN_FLD_W +: GAIN_FLD_W] <= fld;
      end
      assign O_GAIN_CODE[g*GAIN_CODE_W +: GAIN_CODE_W] = gain_reg[g*GAIN_FLD_W +: GAIN_CODE_W];
      assign O_AC_COUPLE[g] = gain_reg[g*GAIN_FLD_W + GAIN_CODE_W];
    end
  endgenerate

  // read data latched at setup, from a flop
  wire [WORD_W-1:0] status = {ptr_reg, 6'h00, wfm_armed_reg, underrun_reg, overrun_reg,
                              half1_reg, half0_reg, (wlat_reg >= WFM_LAT_MIN), wfm_run_reg,
                              (dlat_reg >= DIG_LAT_SCANS), stop_seen_reg, busy};
  wire [WORD_W-1:0] rd_mux =
    hit_ctrl ? ctrl_reg :
    hit_en ? WORD_W'(chan_en_reg) :
    hit_gain ? WORD_W'(gain_reg) :
    hit_att ? WORD_W'(atten_reg) :
    hit_len ? WORD_W'(buf_len_reg) :
    hit_post ? post_cnt_reg :
    hit_atr ? atrig_reg :
    hit_tune ? tune_reg :
    hit_div ? WORD_W'({ao_div_reg, 1'b0, ai_div_reg}) :
    hit_st ? status :
    hit_cnt ? cnt_reg : '0;

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) prdata_reg <= '0;
    else if (I_PSEL && !I_PENABLE) prdata_reg <= rd_mux;
  end

  // acquisition sequencer
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= ST_IDLE;
      ptr_reg <= '0;
      cnt_reg <= '0;
      pend_reg <= '0;
      scan_reg <= '0;
      smp_valid_reg <= 1'b0;
      smp_data_reg <= '0;
      smp_addr_reg <= '0;
    end else begin
      state_reg <= state_next;
      // arming clears pointer and count
      if (state_reg == ST_IDLE && cmd[CMD_ARM]) begin
        ptr_reg <= '0;
        cnt_reg <= '0;
      end else if (start_hit || stop_hit) begin
        cnt_reg <= '0;
      end else if (fire) begin
        ptr_reg <= wrap ? '0 : ptr_inc;
        cnt_reg <= cnt_inc;
      end
      // ending the run drops any scan in flight
      if (state_next == ST_IDLE) begin
        pend_reg <= '0;
        smp_valid_reg <= 1'b0;
      end else if (scan_edge && running) begin
        scan_reg <= adc_s2;
        pend_reg <= chan_en_reg;
        if (can_load) smp_valid_reg <= 1'b0;
      end else if (can_load) begin
        smp_valid_reg <= (pend_reg != '0);
        if (pend_reg != '0) begin
          pend_reg[next_ch] <= 1'b0;
          smp_data_reg <= {scan_reg[next_ch*ADC_W +: ADC_W], {(WORD_W-ADC_W){1'b0}}};
          // address tracks write pointer
          smp_addr_reg <= (fire && !wrap) ? ptr_inc : (fire ? '0 : ptr_reg);
        end
      end
    end
  end

  // sticky status flags: hardware set beats software clear
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      stop_seen_reg <= 1'b0;
      half0_reg <= 1'b0;
      half1_reg <= 1'b0;
      overrun_reg <= 1'b0;
      underrun_reg <= 1'b0;
      dlat_reg <= '0;
      dlat_on_reg <= 1'b0;
      above_reg <= 1'b0;
    end else begin
      stop_seen_reg <= stop_hit || (stop_seen_reg && !(state_reg == ST_IDLE && cmd[CMD_ARM]));
      half0_reg <= half0_set || (half0_reg && !w1c[ST_HALF0]);
      half1_reg <= half1_set || (half1_reg && !w1c[ST_HALF1]);
      overrun_reg <= db_clash || scan_overrun || (overrun_reg && !w1c[ST_OVERRUN]);
      underrun_reg <= (upd && !I_WFM_VALID) || (underrun_reg && !w1c[ST_UNDERRUN]);
      if (scan_edge) above_reg <= above;
      // scans until triggered sample clears filter; arm clears it and stops the count
      if ((start_hit && dig_start) || cmd[CMD_ARM]) begin
        dlat_reg <= '0;
        dlat_on_reg <= start_hit;
      end else if (dlat_on_reg && scan_edge && dlat_reg < DIG_LAT_SCANS) begin
        dlat_reg <= dlat_reg + 8'd1;
      end
    end
  end

  // synthesized clock, shared dividers
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      acc_reg <= '0;
      dds_tick_reg <= 1'b0;
      dcnt_reg <= '0;
      ai_tick_reg <= 1'b0;
    end else begin
      acc_reg <= acc_sum[ACC_W-1:0];
      dds_tick_reg <= acc_sum[ACC_W];
      if (dds_tick_reg) dcnt_reg <= DCNT_W'(dcnt_reg + DCNT_W'(1));
      ai_tick_reg <= ai_tick;
    end
  end

  // waveform generation
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      wfm_armed_reg <= 1'b0;
      wfm_run_reg <= 1'b0;
      wlat_reg <= '0;
      dac_load_reg <= 1'b0;
      dac_data_reg <= '0;
    end else begin
      dac_load_reg <= upd;
      if (cmd[CMD_WFM_HALT]) begin
        wfm_armed_reg <= 1'b0;
        wfm_run_reg <= 1'b0;
      end else if (cmd[CMD_WFM_RUN] && !wfm_run_reg) begin
        wfm_armed_reg <= ctrl_reg[CTRL_WFM_TRIG_BIT];
        wfm_run_reg <= !ctrl_reg[CTRL_WFM_TRIG_BIT];
        wlat_reg <= '0;
      end else if (wfm_armed_reg && wfm_dig) begin
        wfm_armed_reg <= 1'b0;
        wfm_run_reg <= 1'b1;
      end
      // updates until triggered data reaches pins
      if (upd && wlat_reg < WFM_LAT_MAX) wlat_reg <= wlat_reg + 8'd1;
      // underrun: outputs hold last value
      if (upd && I_WFM_VALID) begin
        for (int c = 0; c < N_AO; c++) begin
          dac_data_reg[c*DAC_W +: DAC_W] <=
            I_WFM_DATA[c*WORD_W + WORD_W - DAC_W +: DAC_W];
        end
      end
    end
  end

  // outputs
  assign O_PRDATA = prdata_reg;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc_ph && !mapped;
  assign O_ADC_CONV = ai_tick_reg;
  assign O_SYNC_CLK = dds_tick_reg;
  assign O_AAF_RATE = ai_div_reg;
  assign O_AIF_RATE = ao_tot[DIV_W-1:0];
  assign O_ATTEN = atten_reg;
  assign O_SMP_VALID = smp_valid_reg;
  assign O_SMP_DATA = smp_data_reg;
  assign O_SMP_ADDR = smp_addr_reg;
  assign O_WFM_READY = upd;
  assign O_DAC_LOAD = dac_load_reg;
  assign O_DAC_DATA = dac_data_reg;
endmodule : acq_wfm_ctrl

// ---- dv/acq_wfm_ctrl_chk.sv ----
/* checker: stream and converter relations at the block's ports.
   assumes one clock and an async active-high reset. */
`timescale 1ns/1ps
module acq_wfm_ctrl_chk (
  input wire logic I_CLK_SYS, I_RST, I_SMP_READY, O_SMP_VALID, I_WFM_VALID, O_WFM_READY,
  input wire logic O_DAC_LOAD,
  input wire logic [31:0] O_SMP_DATA,
  input wire logic [15:0] O_SMP_ADDR, O_GAIN_CODE,
  input wire logic [63:0] I_WFM_DATA,
  input wire logic [35:0] O_DAC_DATA,
  input wire logic [3:0] O_ATTEN,
  input wire logic [2:0] O_AIF_RATE
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  load_after_tick_a: assert property (O_WFM_READY |=> O_DAC_LOAD)
    else $error("dac load missing after update tick");
  load_needs_tick_a: assert property (O_DAC_LOAD |-> $past(O_WFM_READY))
    else $error("dac load without update tick");
  dac_word_map_a: assert property (O_WFM_READY && I_WFM_VALID |=>
    O_DAC_DATA == {$past(I_WFM_DATA[63:46]), $past(I_WFM_DATA[31:14])})
    else $error("dac codes not from word tops");
  smp_low_zero_a: assert property (O_SMP_VALID |-> O_SMP_DATA[15:0] == 16'h0000)
    else $error("sample word not left justified");
  smp_hold_a: assert property (O_SMP_VALID && !I_SMP_READY |=>
    O_SMP_VALID && $stable(O_SMP_DATA) && $stable(O_SMP_ADDR))
    else $error("sample changed while stalled");
  gain_range_a: assert property ((O_GAIN_CODE[3:0] <= 4'h8) && (O_GAIN_CODE[7:4] <= 4'h8))
    else $error("gain code above top step");
  atten_range_a: assert property ((O_ATTEN[1:0] != 2'h3) && (O_ATTEN[3:2] != 2'h3))
    else $error("attenuation code out of range");
  out_div_floor_a: assert property (O_AIF_RATE >= 3'h2)
    else $error("output divider below fixed /4");
endmodule : acq_wfm_ctrl_chk
bind acq_wfm_ctrl acq_wfm_ctrl_chk chk_u (.*);

// ---- dv/acq_host_model.sv ----
/* host stand-in: drains samples, feeds waveform word pairs.
   assumes the block's clock; stall and starve come from the bench. */
`timescale 1ns/1ps
module acq_host_model (
  input wire logic clk, rst, stall, starve, wfm_ready,
  output logic smp_ready, wfm_valid,
  output logic [63:0] wfm_data
);
  logic ph;
  // stalling host takes every other cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {ph, smp_ready, wfm_valid} <= 3'h0;
      wfm_data <= 64'h0;
    end else begin
      ph <= ~ph;
      smp_ready <= !stall || ph;
      wfm_valid <= !starve;
      if (starve) wfm_data <= ~wfm_data; // withheld data keeps moving
      else if (wfm_ready && wfm_valid) wfm_data <= wfm_data + 64'h0001_4000_0003_C000;
    end
  end
endmodule : acq_host_model

// ---- dv/simultaneous_acq_and_waveform_control_tb.sv ----
/* bench: apb register tests, scan order, trigger modes and waveform feed.
   assumes acq_wfm_pkg and the checker bound to the block. */
`timescale 1ns/1ps
module simultaneous_acq_and_waveform_control_tb;
  import acq_wfm_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, pin = 0, adc_v = 0, stall = 1, starve = 0;
  logic perr, perr_q, conv, smp_v, smp_r, wfm_v, wfm_r;
  logic [7:0] pa = 8'h00, conv_sr = 8'h00;
  logic [6:0] sync = 7'h00;
  logic [31:0] pwd = 32'h0, q, prd, smp_d;
  logic [63:0] adc_d = 64'h0, wfm_d;
  logic [15:0] smp_a, gain, blen = 16'h0400;
  logic [11:0] scan = 12'h000;
  logic [3:0] acc, att, mask = 4'hA, prev = 4'h3;
  int err_total = 0, tests_run = 0, n_take = 0, cyc = 0, t0;
  always #12.5 clk = ~clk;
  acq_wfm_ctrl dut_u (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pw),
    .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(), .O_PSLVERR(perr),
    .I_TRIG_PIN(pin), .I_SYNC_TRIG(sync), .O_ADC_CONV(conv), .I_ADC_VALID(adc_v),
    .I_ADC_DATA(adc_d), .O_AAF_RATE(), .O_GAIN_CODE(gain), .O_AC_COUPLE(acc),
    .O_SMP_VALID(smp_v), .O_SMP_DATA(smp_d), .O_SMP_ADDR(smp_a), .I_SMP_READY(smp_r),
    .I_WFM_VALID(wfm_v), .I_WFM_DATA(wfm_d), .O_WFM_READY(wfm_r), .O_DAC_LOAD(),
    .O_DAC_DATA(), .O_AIF_RATE(), .O_ATTEN(att), .O_SYNC_CLK());
  acq_host_model host_u (.clk(clk), .rst(rst), .stall(stall), .starve(starve),
    .wfm_ready(wfm_r), .smp_ready(smp_r), .wfm_valid(wfm_v), .wfm_data(wfm_d));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // apb master: setup, access until pready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pa, pw, pwd} <= {2'b10, a, w, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (dut_u.O_PREADY !== 1'b1);
    q = prd;
    perr_q = perr;
    {psel, pen} <= 2'b00;
    #1;
  endtask : apb
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(n, e, q);
  endtask : rc
  task automatic takes(input int k);
    for (int i = 0; i < 10000 && n_take < k; i++) @(posedge clk);
  endtask : takes
  task automatic go(input logic [31:0] ctrl);
    apb(OFS_CTRL, 1'b1, ctrl);
    {n_take, prev} = {32'h0, 4'h3};
    apb(OFS_CMD, 1'b1, 32'h1);
  endtask : go
  // next enabled channel, wrapping
  function automatic logic [3:0] nxt(input logic [3:0] m, input logic [3:0] p);
    logic [1:0] c;
    c = p[1:0];
    for (int i = 0; i < 4; i++) begin
      c = c + 2'd1;
      if (m[c]) return {2'b00, c};
    end
    return p;
  endfunction : nxt
  // converter stand-in: valid rises clocks after conversion
  always @(posedge clk) begin
    conv_sr <= {conv_sr[6:0], conv};
    adc_v <= |conv_sr[7:3];
    if (conv) scan <= scan + 12'h001;
    if (conv) adc_d <= {scan, 4'h3, scan, 4'h2, scan, 4'h1, scan, 4'h0};
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      close_out();
    end
    if (smp_v === 1'b1 && smp_r === 1'b1) begin
      prev = nxt(mask, prev);
      n_take++;
      chk("smp_chan", {28'h0, prev}, {28'h0, smp_d[19:16]});
      chk("smp_addr", 1, smp_a < blen);
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rc("chan_en", OFS_CHAN_EN, 32'hF);
    rc("gain_rst", OFS_GAIN, 32'h0001_0842);
    rc("post_cnt", OFS_POST_CNT, 32'h100);
    rc("unmapped", 8'h30, 32'h0);
    chk("slverr", 1, perr_q);
    for (int g = 0; g < 10; g++) begin
      apb(OFS_GAIN, 1'b1, 32'h200 | (g << 5));
      chk("gain_ch1", g > 8 ? 8 : g, gain[7:4]);
      chk("ac_ch1", 1, acc[1]);
    end
    for (int a = 0; a < 4; a++) begin
      apb(OFS_ATTEN, 1'b1, a << 2);
      chk("atten_ch1", a > 2 ? 2 : a, att[3:2]);
    end
    $display("regs done");
    apb(OFS_CHAN_EN, 1'b1, 32'hA);
    apb(OFS_POST_CNT, 1'b1, 32'h6);
    go(32'h0);
    apb(OFS_CMD, 1'b1, 32'h2);
    takes(6);
    repeat (800) @(posedge clk);
    chk("post_takes", 6, n_take);
    rc("post_count", OFS_COUNT, 32'h6);
    $display("post done");
    {mask, blen} = {4'h4, 16'h0004};
    apb(OFS_CHAN_EN, 1'b1, 32'h4);
    apb(OFS_BUF_LEN, 1'b1, 32'h4);
    apb(OFS_POST_CNT, 1'b1, 32'h3);
    go(32'h1);
    apb(OFS_CMD, 1'b1, 32'h2);
    takes(6);
    t0 = n_take;
    apb(OFS_CMD, 1'b1, 32'h4);
    repeat (1200) @(posedge clk);
    chk("pre_tail", t0 + 3, n_take);
    $display("pre done");
    blen = 16'h0400;
    apb(OFS_BUF_LEN, 1'b1, 32'h400);
    for (int s = 1; s < 3; s++) begin
      go((s << 2) | 32'h500);
      if (s == 1) pin <= 1'b1;
      else sync[5] <= 1'b1;
      apb(OFS_STATUS, 1'b0, 32'h0);
      chk("lat_early", 0, q[ST_DIG_LAT]);
      {pin, sync} <= 8'h00;
      takes(44);
      apb(OFS_STATUS, 1'b0, 32'h0);
      chk("lat_done", 1, q[ST_DIG_LAT]);
      apb(OFS_CMD, 1'b1, 32'h8);
    end
    $display("dig trig done");
    apb(OFS_CTRL, 1'b1, 32'h0);
    apb(OFS_CMD, 1'b1, 32'h10);
    repeat (3000) @(posedge clk);
    rc("wfm_run", OFS_STATUS, 32'h0003_000C);
    starve <= 1'b1;
    repeat (2000) @(posedge clk);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk("underrun", 1, q[ST_UNDERRUN]);
    $display("wfm done");
    close_out();
  end
endmodule : simultaneous_acq_and_waveform_control_tb
